// ---- logic/dao_pkg.sv ----
package dao_pkg;

    // Resolution
    localparam int BASE_BITS_16 = 16;
    localparam int BASE_BITS_14 = 14;
    localparam int BOOST_BITS   = 2;
    localparam int MAX_BITS     = 18;

    // Primary configuration register field positions
    localparam int CFG_WIDTH      = 12;
    localparam int MODE_SEL_POS   = 9;
    localparam int RATIO_MSB      = 8;
    localparam int RATIO_LSB      = 6;
    localparam int BOOST_POS      = 10;
    localparam logic [11:0] CFG_RESET = 12'h000;

    // Ratio codes
    localparam logic [2:0] RATIO_OFF = 3'h0;
    localparam logic [2:0] RATIO_MAX = 3'h5;

    // Timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int INTERNAL_RATE_KSPS = 3000;
    localparam int SAMPLE_GAP_CYC     = (1000000 / INTERNAL_RATE_KSPS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RATIO_LATENCY      = 2;
    localparam int HIST_DEPTH         = 8;
    localparam int SETTLE_TIME_US     = 5000;
    localparam int SETTLE_CYC         = SETTLE_TIME_US * 1000 / CLK_PERIOD_NS;

    typedef struct packed {
        logic        valid;
        logic [17:0] code_a;
        logic [17:0] code_b;
    } dao_sample_s;

endpackage

// ---- logic/dao_shift_out.sv ----
`timescale 1ns/100ps
// Shifts one signed result MSB first, one bit per frame clock pulse
module dao_shift_out #(
    parameter int W = 18
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    // Control
    input  wire logic         load_i,
    input  wire logic [W-1:0] word_i,
    input  wire logic         shift_i,
    // Serial bit
    output logic              bit_o
);
    logic [W-1:0] shreg;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            shreg <= '0;
        end else if (load_i) begin
            shreg <= word_i;
        end else if (shift_i) begin
            shreg <= {shreg[W-2:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bit_o <= 1'b0;
        end else if (load_i) begin
            bit_o <= word_i[W-1];
        end else if (shift_i) begin
            bit_o <= shreg[W-2];
        end
    end
endmodule // dao_shift_out

// ---- logic/dao_average.sv ----
`timescale 1ns/100ps
// Overview of operation
// - Each conversion delivers one result for channel A and a separate one for channel B.
// - Results are two's complement and leave on the serial outputs most significant bit first.
// - The result is 14 or 16 bits by variant, two bits wider with resolution boost, at most 18.
// - Frames and accesses during the settling time are fully served and enter the history; settling only sets settled_o.
// - Bit 9 of the primary configuration selects the averaging mode and bits 8 to 6 the ratio.
// - Two averaging modes, normal and rolling, each average several conversions of one input.
// - Mode 0 is normal, 1 rolling; ratio 000 is off, 001 to 101 give 2 to 32, effective two cycles late.
// - Normal mode starts on chip-select fall, takes the rest at 3 MSPS, sums, divides, shows next access.
// - Every conversion enters an eight-deep history; rolling output sums the newest ratio entries, at most eight, and divides by the ratio.
// - Boost with active averaging gives 18 bits on the 16-bit variant and 16 on the 14-bit variant.
module dao_average #(
    parameter int BASE_BITS  = dao_pkg::BASE_BITS_16,
    parameter int SETTLE_CYC = dao_pkg::SETTLE_CYC
) (
    // Clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         sys_rst_i,
    // Host frame pins
    input  wire logic                         cs_n_i,
    input  wire logic                         sclk_i,
    // Configuration write
    input  wire logic                         cfg_we_i,
    input  wire logic [dao_pkg::CFG_WIDTH-1:0] cfg_data_i,
    // Converter core
    output logic                              conv_start_o,
    input  wire dao_pkg::dao_sample_s         conv_i,
    // Serial outputs
    output logic                              serial_out_chan_a_o,
    output logic                              serial_out_chan_b_or_flag_o,
    // Status
    output logic                              settled_o,
    output logic [4:0]                        result_bits_o
);
    localparam int HD = dao_pkg::HIST_DEPTH;

    // Pin synchronisers
    logic [1:0] cs_sync;
    logic [1:0] sclk_sync;
    logic       cs_prev;
    logic       sclk_prev;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cs_sync   <= 2'h3;
            sclk_sync <= 2'h0;
            cs_prev   <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            cs_sync   <= {cs_sync[0], cs_n_i};
            sclk_sync <= {sclk_sync[0], sclk_i};
            cs_prev   <= cs_sync[1];
            sclk_prev <= sclk_sync[1];
        end
    end
    wire cs_fall   = cs_prev && !cs_sync[1];
    wire sclk_rise = !sclk_prev && sclk_sync[1] && !cs_sync[1];

    // Configuration, ratio delayed two cycles
    logic [dao_pkg::CFG_WIDTH-1:0] cfg;
    logic [2:0]                    ratio_d1;
    logic [2:0]                    ratio;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cfg      <= dao_pkg::CFG_RESET;
            ratio_d1 <= dao_pkg::RATIO_OFF;
            ratio    <= dao_pkg::RATIO_OFF;
        end else begin
            if (cfg_we_i) begin
                cfg <= cfg_data_i;
            end
            ratio_d1 <= cfg[dao_pkg::RATIO_MSB:dao_pkg::RATIO_LSB];
            ratio    <= ratio_d1;
        end
    end
    wire       mode_rolling = cfg[dao_pkg::MODE_SEL_POS];
    wire       avg_on       = (ratio != dao_pkg::RATIO_OFF) && (ratio <= dao_pkg::RATIO_MAX);
    wire       boost        = cfg[dao_pkg::BOOST_POS] && avg_on;
    wire [5:0] n_samples    = avg_on ? 6'(1 << ratio) : 6'h01;
    wire [2:0] shift_amt    = avg_on ? ratio : 3'h0;

    // Settling counter: frames are fully served meanwhile, only flagged
    logic [31:0] settle_cnt;
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            settle_cnt <= '0;
            settled_o  <= 1'b0;
        end else if (settle_cnt < 32'(SETTLE_CYC)) begin
            settle_cnt <= settle_cnt + 32'h1;
        end else begin
            settled_o <= 1'b1;
        end
    end

    // History of completed conversions, A and B
    logic signed [17:0] hist_a [HD];
    logic signed [17:0] hist_b [HD];
    genvar gi;
    generate
        for (gi = 0; gi < HD; gi++) begin : g_hist
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    hist_a[gi] <= '0;
                    hist_b[gi] <= '0;
                end else if (conv_i.valid) begin
                    hist_a[gi] <= (gi == 0) ? conv_i.code_a : hist_a[(gi == 0) ? 0 : gi-1];
                    hist_b[gi] <= (gi == 0) ? conv_i.code_b : hist_b[(gi == 0) ? 0 : gi-1];
                end
            end
        end
    endgenerate

    // Rolling sums of newest ratio entries, at most the eight held
    logic signed [22:0] roll_a;
    logic signed [22:0] roll_b;
    always_comb begin
        roll_a = '0;
        roll_b = '0;
        for (int i = 0; i < HD; i++) begin
            if (6'(i) < n_samples) begin
                roll_a = roll_a + 23'(hist_a[i]);
                roll_b = roll_b + 23'(hist_b[i]);
            end
        end
    end

    // Normal averaging sequencer
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_GAP} dao_seq_e;
    dao_seq_e           state;
    logic [5:0]         taken;
    logic [7:0]         gap;
    logic signed [22:0] acc_a;
    logic signed [22:0] acc_b;
    logic signed [22:0] res_a;
    logic signed [22:0] res_b;
    wire normal_avg = avg_on && !mode_rolling;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state        <= ST_IDLE;
            taken        <= '0;
            gap          <= '0;
            acc_a        <= '0;
            acc_b        <= '0;
            res_a        <= '0;
            res_b        <= '0;
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (cs_fall) begin
                        conv_start_o <= 1'b1;
                        acc_a        <= '0;
                        acc_b        <= '0;
                        taken        <= '0;
                        state        <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (conv_i.valid) begin
                        if (normal_avg) begin
                            // Codes are two's complement: sign-extend before summing
                            if (taken + 6'h1 == n_samples) begin
                                res_a <= (acc_a + 23'($signed(conv_i.code_a))) >>> shift_amt;
                                res_b <= (acc_b + 23'($signed(conv_i.code_b))) >>> shift_amt;
                                state <= ST_IDLE;
                            end else begin
                                acc_a <= acc_a + 23'($signed(conv_i.code_a));
                                acc_b <= acc_b + 23'($signed(conv_i.code_b));
                                taken <= taken + 6'h1;
                                gap   <= 8'(dao_pkg::SAMPLE_GAP_CYC);
                                state <= ST_GAP;
                            end
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_GAP: begin
                    if (gap <= 8'h1) begin
                        conv_start_o <= 1'b1;
                        state        <= ST_WAIT;
                    end else begin
                        gap <= gap - 8'h1;
                    end
                end
            endcase
        end
    end

    // Output word selection and width
    wire signed [22:0] avg_a = !avg_on ? 23'(hist_a[0]) : (mode_rolling ? (roll_a >>> shift_amt) : res_a);
    wire signed [22:0] avg_b = !avg_on ? 23'(hist_b[0]) : (mode_rolling ? (roll_b >>> shift_amt) : res_b);
    wire [4:0] width  = 5'(BASE_BITS) + (boost ? 5'(dao_pkg::BOOST_BITS) : 5'h0);
    // Core codes carry full 18-bit precision; drop the guard bits not shown
    wire [4:0] drop   = 5'(dao_pkg::MAX_BITS) - width;
    wire [17:0] word_a = 18'(avg_a >>> drop) << (5'(dao_pkg::MAX_BITS) - width);
    wire [17:0] word_b = 18'(avg_b >>> drop) << (5'(dao_pkg::MAX_BITS) - width);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            result_bits_o <= 5'(BASE_BITS);
        end else begin
            result_bits_o <= width;
        end
    end

    dao_shift_out #(.W(dao_pkg::MAX_BITS)) u_out_a (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (cs_fall),
        .word_i    (word_a),
        .shift_i   (sclk_rise),
        .bit_o     (serial_out_chan_a_o)
    );

    dao_shift_out #(.W(dao_pkg::MAX_BITS)) u_out_b (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .load_i    (cs_fall),
        .word_i    (word_b),
        .shift_i   (sclk_rise),
        .bit_o     (serial_out_chan_b_or_flag_o)
    );

    chk_ratio_latency: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        ##2 (ratio == $past(cfg[dao_pkg::RATIO_MSB:dao_pkg::RATIO_LSB], 2)))
        else $error("ratio not applied two cycles after write");

    chk_illegal_ratio_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (ratio > dao_pkg::RATIO_MAX) |-> (!boost && avg_a == 23'(hist_a[0])))
        else $error("illegal ratio code did not disable averaging");

    chk_width_boost: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        boost |=> (result_bits_o == 5'(BASE_BITS + dao_pkg::BOOST_BITS)))
        else $error("boosted width wrong");

    chk_start_on_fall: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (cs_fall && state == ST_IDLE) |=> conv_start_o)
        else $error("no conversion start after chip-select fall");

    chk_history_shift: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        conv_i.valid |=> (hist_a[0] == $past(conv_i.code_a)) && (hist_a[1] == $past(hist_a[0])))
        else $error("history did not shift on conversion");

    chk_load_msb_first: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cs_fall |=> (serial_out_chan_a_o == $past(word_a[17])) && (serial_out_chan_b_or_flag_o == $past(word_b[17])))
        else $error("first serial bit is not the result sign bit");
endmodule // dao_average

// ---- verification/dao_host_model.sv ----
`timescale 1ns/100ps
// Host stand-in: frames each read with chip select, sclk idles low between frames
module dao_host_model (
    // Clock
    input  wire logic mclk_i,
    // Serial data from the device
    input  wire logic sdo_a_i,
    input  wire logic sdo_b_i,
    // Frame pins
    output logic      cs_n_o,
    output logic      sclk_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // Bits are taken before the sclk rise that retires them; both pins pass a two-stage sync
    task automatic frame(input int w, output logic [17:0] a, output logic [17:0] b);
        a = '0;
        b = '0;
        gap(4);
        cs_n_o = 1'b0;
        for (int i = 0; i < w; i++) begin
            gap(6);
            a = {a[16:0], sdo_a_i};
            b = {b[16:0], sdo_b_i};
            sclk_o = 1'b1;
            gap(5);
            sclk_o = 1'b0;
        end
        gap(6);
        cs_n_o = 1'b1;
    endtask
endmodule // dao_host_model

// ---- verification/dao_average_tb.sv ----
`timescale 1ns/100ps
module dao_average_tb;
    localparam int SETTLE = 20;
    logic                            mclk_i = 1'b0;
    logic                            sys_rst_i = 1'b1;
    logic                            cfg_we_i = 1'b0;
    logic [dao_pkg::CFG_WIDTH-1:0]   cfg_data_i = 12'h000;
    dao_pkg::dao_sample_s            conv_i = '0;
    logic                            cs_n, sclk, conv_start, sdo_a, sdo_b, settled;
    logic [4:0]                      result_bits;
    logic [15:0]                     lfsr = 16'h0025;
    logic [11:0]                     tbl [12] = '{12'h000, 12'h2C0, 12'h640, 12'h740, 12'h040, 12'h540,
                                                  12'h480, 12'h780, 12'h5C0, 12'h300, 12'h0C0, 12'h600};
    int                              mismatches = 0;
    int                              n_checks = 0;
    bit                              hung = 1'b0;
    int                              hist_a[$], hist_b[$];
    int                              cur_a, cur_b, last_a, last_b, n_conv, mode, k, n, boost;

    always #5 mclk_i = ~mclk_i;

    dao_average #(.BASE_BITS(dao_pkg::BASE_BITS_16), .SETTLE_CYC(SETTLE)) u_dao_average (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .cfg_we_i(cfg_we_i),
        .cfg_data_i(cfg_data_i), .conv_start_o(conv_start), .conv_i(conv_i), .serial_out_chan_a_o(sdo_a),
        .serial_out_chan_b_or_flag_o(sdo_b), .settled_o(settled), .result_bits_o(result_bits));
    dao_host_model u_dao_host_model (.mclk_i(mclk_i), .sdo_a_i(sdo_a), .sdo_b_i(sdo_b), .cs_n_o(cs_n),
        .sclk_o(sclk));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Reference: every conversion enters the history; the latest result follows the active mode
    task automatic record();
        int sa, sb;
        sa = 0;
        sb = 0;
        hist_a.push_back(cur_a);
        hist_b.push_back(cur_b);
        if (hist_a.size() > dao_pkg::HIST_DEPTH) begin
            void'(hist_a.pop_front());
            void'(hist_b.pop_front());
        end
        n_conv++;
        if (mode == 0 && k > 0) begin
            if (n_conv == n) begin
                last_a = cur_a;
                last_b = cur_b;
            end
        end else begin
            for (int i = 0; i < n && i < dao_pkg::HIST_DEPTH; i++) begin
                sa += hist_a[hist_a.size() - 1 - i];
                sb += hist_b[hist_b.size() - 1 - i];
            end
            last_a = sa >>> k;
            last_b = sb >>> k;
        end
    endtask

    // Converter core stand-in: one answer per start request, carrying this frame's input
    always @(negedge mclk_i) begin
        if (conv_start === 1'b1) begin
            repeat (4) @(posedge mclk_i);
            #1;
            conv_i.code_a = 18'(cur_a);
            conv_i.code_b = 18'(cur_b);
            conv_i.valid = 1'b1;
            record();
            @(posedge mclk_i);
            #1;
            conv_i.valid = 1'b0;
        end
    end

    function automatic int width();
        return (boost != 0 && k > 0) ? dao_pkg::MAX_BITS : dao_pkg::BASE_BITS_16;
    endfunction

    task automatic write_cfg(input logic [11:0] v);
        @(posedge mclk_i);
        #1;
        cfg_data_i = v;
        cfg_we_i = 1'b1;
        @(posedge mclk_i);
        #1;
        cfg_we_i = 1'b0;
        mode = v[dao_pkg::MODE_SEL_POS];
        boost = v[dao_pkg::BOOST_POS];
        k = (v[8:6] >= 3'h1 && v[8:6] <= dao_pkg::RATIO_MAX) ? int'(v[8:6]) : 0;
        n = 1 << k;
        repeat (6) @(posedge mclk_i);
        check(18'(result_bits), 18'(width()));
    endtask

    // The first read after a change carries the old setting, so the host drops it
    task automatic do_frame(input bit cmp);
        logic [17:0] ga, gb, msk;
        int          w, need, cnt, ea, eb;
        w = width();
        msk = 18'h3FFFF >> (18 - w);
        lfsr = lfsr_next(lfsr);
        cur_a = int'($signed({lfsr[3:2], lfsr}));
        lfsr = lfsr_next(lfsr);
        cur_b = int'($signed({lfsr[5:4], lfsr}));
        need = (mode == 0 && k > 0) ? n : 1;
        n_conv = 0;
        // The frame shows the result finished before its own chip-select fall
        ea = last_a;
        eb = last_b;
        u_dao_host_model.frame(w, ga, gb);
        if (cmp) begin
            check(ga, 18'(ea >>> (18 - w)) & msk);
            check(gb, 18'(eb >>> (18 - w)) & msk);
        end
        for (cnt = 0; cnt < 3000 && n_conv < need; cnt++) begin
            @(posedge mclk_i);
        end
        if (n_conv < need) begin
            mismatches++;
            hung = 1'b1;
        end else begin
            repeat (60) @(posedge mclk_i);
            check(18'(n_conv), 18'(need));
        end
    endtask

    initial begin
        repeat (dao_pkg::HIST_DEPTH) hist_a.push_back(0);
        repeat (dao_pkg::HIST_DEPTH) hist_b.push_back(0);
        mode = 0;
        k = 0;
        n = 1;
        boost = 0;
        last_a = 0;
        last_b = 0;
        repeat (6) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        check(18'(settled), 18'h00000);
        do_frame(1'b0);
        check(18'(settled), 18'h00001);
        for (int c = 0; c < 12 && !hung; c++) begin
            write_cfg(tbl[c]);
            do_frame(1'b0);
            repeat ((c == 0) ? 10 : 4) begin
                if (!hung) begin
                    do_frame(1'b1);
                end
            end
        end
        test_done();
    end
endmodule // dao_average_tb
